//--- verilog/bdm_core.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Status bits 7 to 5 read zero.
// - Timeout flag set by power-up, clear, sleep.
// - Power-down flag set power-up, clear; sleep clears.
// - Zero flag tracks zero result.
// - Half carry from bit three.
// - Carry from most significant bit.
// - Subtract adds complement; carries mean no borrow.
// - Rotates load carry from shifted-out bit.
// - Flag access types and reset values.
// - Seven-bit offset decodes four regions.
// - Common RAM shared by every bank.
// - Eighty general RAM bytes per bank.
// - General RAM of banks 0 to 30 reachable linearly through pointers.
// - Twelve core registers mirrored in all banks.
// - Unimplemented locations read zero.
// - Thirty-two banks; bank select picks one.
// - Flag writes suppressed when flags updated.
//////////////////////////////////////////////////////////////////////////////
module bdm_core #(
  parameter int NUM_BANKS = 32,
  parameter int RAM_BANKS = 32
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Reset cause: high when the reset was power-on or brown-out.
  input wire logic por_reset,
  // Data memory access from the execution logic.
  input wire bdm_pkg::bdm_acc_t acc,
  output logic [7:0] rdata,
  // ALU operation and destination.
  input wire bdm_pkg::bdm_alu_req_t alu_req,
  input wire logic alu_valid,
  output logic [7:0] alu_result,
  // Power management events.
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic wdt_expired,
  // Peripheral register window.
  output logic periph_sel,
  output logic periph_we,
  output logic [11:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata,
  // Status view.
  output logic [7:0] status,
  output logic [4:0] bank
);

  // The decoder is built for the full bank count; fewer fitted RAM banks
  // simply read zero above the last one.
  if (NUM_BANKS != bdm_pkg::NUM_BANKS || RAM_BANKS < 1
      || RAM_BANKS > NUM_BANKS) begin : g_bad_banks
    $error("bdm_core bank counts are not supported.");
  end

  localparam int RAM_DEPTH = RAM_BANKS * bdm_pkg::GENRAM_BYTES;
  localparam int RAM_AW = 12;

  //////////////////////////////////////////////////////////////////////////
  // Core registers.
  logic [7:0] pc_low_reg;
  logic [7:0] p0l_reg;
  logic [7:0] p0h_reg;
  logic [7:0] p1l_reg;
  logic [7:0] p1h_reg;
  logic [7:0] bank_select_reg;
  logic [7:0] working_reg;
  logic [7:0] pc_latch_reg;
  logic [7:0] irq_ctrl_reg;
  logic to_n_reg;
  logic pd_n_reg;
  logic z_reg;
  logic dc_reg;
  logic c_reg;
  logic por_seen_reg;

  //////////////////////////////////////////////////////////////////////////
  // Address formation.
  wire logic [6:0] off = acc.offset;
  wire logic [15:0] ptr = acc.sel ? {p1h_reg, p1l_reg} : {p0h_reg, p0l_reg};
  wire logic [4:0] bsel = bank_select_reg[4:0];
  wire logic [11:0] direct_addr = {bsel, off};

  // Indirect pointers reach banked space below the linear window.
  wire logic lin_hit = ptr >= bdm_pkg::LINEAR_BASE
    && ptr <= bdm_pkg::LINEAR_LAST;
  wire logic [15:0] lin_idx = ptr - bdm_pkg::LINEAR_BASE;
  wire logic ind_bank = !ptr[15] && ptr[14:12] == 3'b000;
  wire logic [11:0] eff_addr = !acc.indirect ? direct_addr : ptr[11:0];
  wire logic [6:0] eoff = eff_addr[6:0];
  wire logic [4:0] ebank = eff_addr[11:7];
  wire logic banked_ok = !acc.indirect || ind_bank;

  //////////////////////////////////////////////////////////////////////////
  // Region decode.
  wire logic r_core = banked_ok && eoff <= bdm_pkg::CORE_LAST;
  wire logic r_periph = banked_ok && eoff >= bdm_pkg::PERIPH_FIRST
    && eoff <= bdm_pkg::PERIPH_LAST;
  wire logic r_ram = banked_ok && eoff >= bdm_pkg::GENRAM_FIRST
    && eoff <= bdm_pkg::GENRAM_LAST;
  wire logic r_common = banked_ok
    && eoff >= bdm_pkg::COMMON_FIRST;
  wire logic r_lin = acc.indirect && lin_hit;
  // Indirection through an indirect data register is not chained.
  wire logic r_loop = acc.indirect && r_core
    && eoff <= bdm_pkg::OFF_INDIRECT_DATA_1;

  wire logic [6:0] ram_off = 7'(eoff - bdm_pkg::GENRAM_FIRST);
  wire logic [11:0] ram_bank_idx = 12'(ebank) * 12'(bdm_pkg::GENRAM_BYTES)
    + {5'h00, ram_off};
  wire logic ram_bank_ok = 32'(ebank) < RAM_BANKS;
  wire logic [11:0] ram_idx = r_lin ? lin_idx[11:0] : ram_bank_idx;
  wire logic ram_hit = r_lin || (r_ram && ram_bank_ok);
  wire logic ram_in = 32'(ram_idx) < RAM_DEPTH;

  //////////////////////////////////////////////////////////////////////////
  // Write strobes.
  wire logic wr = acc.wr;
  wire logic core_wr = wr && r_core && !r_loop;
  wire logic [7:0] wdata = alu_valid ? alu_result : acc.wdata;
  wire logic st_wr = core_wr && eoff == bdm_pkg::OFF_CORE_STATUS;

  //////////////////////////////////////////////////////////////////////////
  // ALU.
  bdm_pkg::bdm_alu_rsp_t alu_rsp;

  bdm_alu u_alu (
    .req(alu_req),
    .carry_in(c_reg),
    .rsp(alu_rsp)
  );

  assign alu_result = alu_rsp.result;

  //////////////////////////////////////////////////////////////////////////
  // RAM blocks.
  wire logic [7:0] ram_rdata;
  wire logic [7:0] com_rdata;

  bdm_ram #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_genram (
    .ref_clk(ref_clk),
    .we(wr && ram_hit && ram_in),
    .addr(ram_idx),
    .wdata(wdata),
    .rdata(ram_rdata)
  );

  // One bank-independent array: the offset alone indexes it.
  bdm_ram #(.DEPTH(bdm_pkg::COMMON_BYTES), .AW(4)) u_common (
    .ref_clk(ref_clk),
    .we(wr && r_common),
    .addr(eoff[3:0]),
    .wdata(wdata),
    .rdata(com_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Status next state.
  wire logic upd_z = alu_valid && alu_rsp.upd_z;
  wire logic upd_dc = alu_valid && alu_rsp.upd_dc;
  wire logic upd_c = alu_valid && alu_rsp.upd_c;
  wire logic z_next = upd_z ? alu_rsp.z
    : st_wr ? wdata[bdm_pkg::ST_ZERO] : z_reg;
  wire logic dc_next = upd_dc ? alu_rsp.dc
    : st_wr ? wdata[bdm_pkg::ST_HALF_CARRY] : dc_reg;
  wire logic c_next = upd_c ? alu_rsp.c
    : st_wr ? wdata[bdm_pkg::ST_CARRY] : c_reg;

  // The expiry wins if it meets a clear in the same cycle.
  wire logic to_n_next = wdt_expired ? 1'b0
    : (watchdog_clear_instr || sleep_instr) ? 1'b1 : to_n_reg;
  wire logic pd_n_next = sleep_instr ? 1'b0
    : watchdog_clear_instr ? 1'b1 : pd_n_reg;

  //////////////////////////////////////////////////////////////////////////
  // Sequential state.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      to_n_reg <= bdm_pkg::ST_FLAG_N_RST;
      pd_n_reg <= bdm_pkg::ST_FLAG_N_RST;
      por_seen_reg <= 1'b1;
    end else begin
      to_n_reg <= to_n_next;
      pd_n_reg <= pd_n_next;
      por_seen_reg <= 1'b0;
    end
  end

  // Arithmetic flags survive non power-on resets, so they have no async
  // clear; a power-on cause clears them on the first edge after release.
  always_ff @(posedge ref_clk) begin
    if (por_seen_reg && por_reset) begin
      z_reg <= bdm_pkg::ST_ALU_RST;
      dc_reg <= bdm_pkg::ST_ALU_RST;
      c_reg <= bdm_pkg::ST_ALU_RST;
    end else begin
      z_reg <= z_next;
      dc_reg <= dc_next;
      c_reg <= c_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core register write decode.
  wire logic wr_pc_low = core_wr
    && eoff == bdm_pkg::OFF_PROGRAM_COUNTER_LOW;
  wire logic wr_p0_low = core_wr && eoff == bdm_pkg::OFF_POINTER0_LOW;
  wire logic wr_p0_high = core_wr && eoff == bdm_pkg::OFF_POINTER0_HIGH;
  wire logic wr_p1_low = core_wr && eoff == bdm_pkg::OFF_POINTER1_LOW;
  wire logic wr_p1_high = core_wr && eoff == bdm_pkg::OFF_POINTER1_HIGH;
  wire logic wr_bank_sel = core_wr && eoff == bdm_pkg::OFF_BANK_SELECT;
  wire logic wr_working = core_wr
    && eoff == bdm_pkg::OFF_WORKING_REGISTER;
  wire logic wr_pc_latch = core_wr
    && eoff == bdm_pkg::OFF_PROGRAM_COUNTER_LATCH_HIGH;
  wire logic wr_irq_ctrl = core_wr
    && eoff == bdm_pkg::OFF_INTERRUPT_CONTROL;

  //////////////////////////////////////////////////////////////////////////
  // Core register next values.
  wire logic [7:0] pc_low_next = wr_pc_low ? wdata : pc_low_reg;
  wire logic [7:0] p0l_next = wr_p0_low ? wdata : p0l_reg;
  wire logic [7:0] p0h_next = wr_p0_high ? wdata : p0h_reg;
  wire logic [7:0] p1l_next = wr_p1_low ? wdata : p1l_reg;
  wire logic [7:0] p1h_next = wr_p1_high ? wdata : p1h_reg;
  // Only five bank bits exist, so the upper three always read zero.
  wire logic [7:0] bank_select_next = wr_bank_sel
    ? {3'b000, wdata[4:0]} : bank_select_reg;
  wire logic [7:0] working_next = wr_working ? wdata : working_reg;
  wire logic [7:0] pc_latch_next = wr_pc_latch
    ? {1'b0, wdata[6:0]} : pc_latch_reg;
  wire logic [7:0] irq_ctrl_next = wr_irq_ctrl ? wdata : irq_ctrl_reg;

  //////////////////////////////////////////////////////////////////////////
  // Core registers, one short process each.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_low_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      pc_low_reg <= pc_low_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p0l_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      p0l_reg <= p0l_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p0h_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      p0h_reg <= p0h_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p1l_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      p1l_reg <= p1l_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      p1h_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      p1h_reg <= p1h_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bank_select_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      bank_select_reg <= bank_select_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      working_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      working_reg <= working_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pc_latch_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      pc_latch_reg <= pc_latch_next;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_ctrl_reg <= bdm_pkg::CORE_REG_RST;
    end else begin
      irq_ctrl_reg <= irq_ctrl_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read path.
  assign status = {3'b000, to_n_reg, pd_n_reg, z_reg, dc_reg, c_reg};
  assign bank = bsel;

  logic [7:0] core_rd;

  always_comb begin
    unique case (eoff[3:0])
      4'h2: core_rd = pc_low_reg;
      4'h3: core_rd = status;
      4'h4: core_rd = p0l_reg;
      4'h5: core_rd = p0h_reg;
      4'h6: core_rd = p1l_reg;
      4'h7: core_rd = p1h_reg;
      4'h8: core_rd = bank_select_reg;
      4'h9: core_rd = working_reg;
      4'ha: core_rd = pc_latch_reg;
      4'hb: core_rd = irq_ctrl_reg;
      default: core_rd = 8'h00;
    endcase
  end

  assign periph_sel = r_periph && !r_lin;
  assign periph_we = wr && periph_sel;
  assign periph_addr = eff_addr;
  assign periph_wdata = wdata;

  // Anything not decoded, including RAM beyond the fitted banks, is zero.
  assign rdata = r_lin ? (ram_in ? ram_rdata : 8'h00)
    : (r_core && !r_loop) ? core_rd
    : periph_sel ? periph_rdata
    : (ram_hit && ram_in) ? ram_rdata
    : r_common ? com_rdata
    : 8'h00;

endmodule

//--- verilog/bdm_pkg.sv
package bdm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Geometry.
  localparam int OFFSET_W = 7;
  localparam int BANK_W = 5;
  localparam int ADDR_W = BANK_W + OFFSET_W;
  localparam int NUM_BANKS = 32;
  localparam int BANK_BYTES = 128;
  localparam int CORE_REGS = 12;
  localparam int GENRAM_BYTES = 80;
  localparam int COMMON_BYTES = 16;

  //////////////////////////////////////////////////////////////////////////
  // Region boundaries inside a bank.
  localparam logic [6:0] CORE_LAST = 7'h0b;
  localparam logic [6:0] PERIPH_FIRST = 7'h0c;
  localparam logic [6:0] PERIPH_LAST = 7'h1f;
  localparam logic [6:0] GENRAM_FIRST = 7'h20;
  localparam logic [6:0] GENRAM_LAST = 7'h6f;
  localparam logic [6:0] COMMON_FIRST = 7'h70;

  //////////////////////////////////////////////////////////////////////////
  // Core register offsets.
  localparam logic [6:0] OFF_INDIRECT_DATA_0 = 7'h00;
  localparam logic [6:0] OFF_INDIRECT_DATA_1 = 7'h01;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFF_CORE_STATUS = 7'h03;
  localparam logic [6:0] OFF_POINTER0_LOW = 7'h04;
  localparam logic [6:0] OFF_POINTER0_HIGH = 7'h05;
  localparam logic [6:0] OFF_POINTER1_LOW = 7'h06;
  localparam logic [6:0] OFF_POINTER1_HIGH = 7'h07;
  localparam logic [6:0] OFF_BANK_SELECT = 7'h08;
  localparam logic [6:0] OFF_WORKING_REGISTER = 7'h09;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_LATCH_HIGH = 7'h0a;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0b;

  //////////////////////////////////////////////////////////////////////////
  // Status fields and reset values.
  localparam int ST_CARRY = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  localparam logic ST_FLAG_N_RST = 1'b1;
  localparam logic ST_ALU_RST = 1'b0;
  localparam logic [7:0] CORE_REG_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Linear view of general RAM through the pointers.
  localparam logic [15:0] LINEAR_BASE = 16'h2000;
  localparam logic [15:0] LINEAR_LAST = 16'h29af;

  //////////////////////////////////////////////////////////////////////////
  // ALU operations.
  typedef enum logic [3:0] {
    BDM_OP_NONE = 4'h0,
    BDM_OP_ADD = 4'h1,
    BDM_OP_SUB = 4'h2,
    BDM_OP_AND = 4'h3,
    BDM_OP_OR = 4'h4,
    BDM_OP_XOR = 4'h5,
    BDM_OP_ROR = 4'h6,
    BDM_OP_ROL = 4'h7,
    BDM_OP_PASS = 4'h8,
    BDM_OP_CLR = 4'h9
  } bdm_op_t;

  typedef struct packed {
    bdm_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } bdm_alu_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic upd_z;
    logic upd_dc;
    logic upd_c;
    logic z;
    logic dc;
    logic c;
  } bdm_alu_rsp_t;

  typedef struct packed {
    logic wr;
    logic indirect;
    logic sel;
    logic [6:0] offset;
    logic [7:0] wdata;
  } bdm_acc_t;

endpackage

//--- verilog/bdm_alu.sv
`timescale 1ns/100ps
module bdm_alu (
  // Operation in.
  input wire bdm_pkg::bdm_alu_req_t req,
  input wire logic carry_in,
  // Result and flags out.
  output bdm_pkg::bdm_alu_rsp_t rsp
);

  // Subtraction adds the two's complement, so carries mean no borrow.
  wire logic [7:0] sub_b = ~req.b;
  wire logic [8:0] sum_add = {1'b0, req.a} + {1'b0, req.b};
  wire logic [8:0] sum_sub = {1'b0, req.a} + {1'b0, sub_b} + 9'h001;
  wire logic [4:0] nib_add = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
  wire logic [4:0] nib_sub = {1'b0, req.a[3:0]} + {1'b0, sub_b[3:0]}
    + 5'h01;

  always_comb begin
    rsp = '0;
    unique case (req.op)
      bdm_pkg::BDM_OP_ADD: begin
        rsp.result = sum_add[7:0];
        rsp.c = sum_add[8];
        rsp.dc = nib_add[4];
        rsp.upd_c = 1'b1;
        rsp.upd_dc = 1'b1;
        rsp.upd_z = 1'b1;
      end
      bdm_pkg::BDM_OP_SUB: begin
        rsp.result = sum_sub[7:0];
        rsp.c = sum_sub[8];
        rsp.dc = nib_sub[4];
        rsp.upd_c = 1'b1;
        rsp.upd_dc = 1'b1;
        rsp.upd_z = 1'b1;
      end
      bdm_pkg::BDM_OP_AND: begin
        rsp.result = req.a & req.b;
        rsp.upd_z = 1'b1;
      end
      bdm_pkg::BDM_OP_OR: begin
        rsp.result = req.a | req.b;
        rsp.upd_z = 1'b1;
      end
      bdm_pkg::BDM_OP_XOR: begin
        rsp.result = req.a ^ req.b;
        rsp.upd_z = 1'b1;
      end
      bdm_pkg::BDM_OP_ROR: begin
        rsp.result = {carry_in, req.a[7:1]};
        rsp.c = req.a[0];
        rsp.upd_c = 1'b1;
      end
      bdm_pkg::BDM_OP_ROL: begin
        rsp.result = {req.a[6:0], carry_in};
        rsp.c = req.a[7];
        rsp.upd_c = 1'b1;
      end
      bdm_pkg::BDM_OP_PASS: begin
        rsp.result = req.a;
      end
      bdm_pkg::BDM_OP_CLR: begin
        rsp.result = 8'h00;
        rsp.upd_z = 1'b1;
      end
      default: begin
        rsp.result = req.a;
      end
    endcase
    rsp.z = (rsp.result == 8'h00);
  end

endmodule

//--- verilog/bdm_ram.sv
`timescale 1ns/100ps
module bdm_ram #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock.
  input wire logic ref_clk,
  // Access port.
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin
      $error("bdm_ram depth does not fit its address width.");
    end
  end

  // Plain storage has no reset; software must initialise it.
  logic [7:0] mem_reg [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
  end

  assign rdata = (32'(addr) < DEPTH) ? mem_reg[addr] : 8'h00;

endmodule

//--- bench/bdm_core_props.sv
`timescale 1ns/100ps
module bdm_core_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic resetn,
  // Execution side.
  input wire bdm_pkg::bdm_acc_t acc,
  input wire bdm_pkg::bdm_alu_req_t alu_req,
  input wire logic alu_valid,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instr,
  input wire logic wdt_expired,
  // Peripheral window and status.
  input wire logic periph_sel,
  input wire logic [11:0] periph_addr,
  input wire logic [7:0] status,
  input wire logic [4:0] bank
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire [8:0] sum9 = {1'b0, alu_req.a} + {1'b0, alu_req.b};
  wire [4:0] sum5 = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]};
  wire is_add = alu_valid && alu_req.op == bdm_pkg::BDM_OP_ADD;
  wire is_sub = alu_valid && alu_req.op == bdm_pkg::BDM_OP_SUB;
  wire is_ror = alu_valid && alu_req.op == bdm_pkg::BDM_OP_ROR;
  wire quiet = !watchdog_clear_instr && !sleep_instr && !wdt_expired;
  wire per = !acc.indirect && acc.offset >= 7'h0c && acc.offset <= 7'h1f;
  wire bsel = acc.wr && !acc.indirect && acc.offset == 7'h08;
  ////////////////////////////////////////////////////////////
  property p_upper;
    status[7:5] == 3'b000;
  endproperty
  a_upper: assert property (p_upper)
    else $error("status upper bits set");
  property p_expire;
    wdt_expired |=> !status[4];
  endproperty
  a_expire: assert property (p_expire)
    else $error("timeout flag not cleared");
  property p_clear;
    watchdog_clear_instr && quiet == 1'b0 && !sleep_instr && !wdt_expired
      |=> status[4:3] == 2'b11;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not set both flags");
  property p_sleep;
    sleep_instr && !wdt_expired |=> status[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep flags wrong");
  property p_hold;
    quiet |=> $stable(status[4:3]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read-only flags changed");
  property p_add;
    is_add |=> status[2:0] ==
      {$past(sum9[7:0]) == 8'h00, $past(sum5[4]), $past(sum9[8])};
  endproperty
  a_add: assert property (p_add)
    else $error("add flags wrong");
  property p_sub;
    is_sub |=> status[0] == $past(alu_req.a >= alu_req.b) &&
      status[1] == $past(alu_req.a[3:0] >= alu_req.b[3:0]);
  endproperty
  a_sub: assert property (p_sub)
    else $error("borrow flags wrong");
  property p_ror;
    is_ror |=> status[0] == $past(alu_req.a[0]);
  endproperty
  a_ror: assert property (p_ror)
    else $error("rotate carry wrong");
  property p_periph;
    per |-> periph_sel && periph_addr == {bank, acc.offset};
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral window wrong");
  property p_bank;
    bsel && !alu_valid |=> bank == $past(acc.wdata[4:0]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select not loaded");
  c_sleep: cover property (sleep_instr ##1 wdt_expired);
  c_sub: cover property (is_sub);
  c_bank: cover property (bsel ##1 per);
endmodule

bind bdm_core bdm_core_props i_props (
  .ref_clk(ref_clk), .resetn(resetn), .acc(acc), .alu_req(alu_req),
  .alu_valid(alu_valid), .watchdog_clear_instr(watchdog_clear_instr),
  .sleep_instr(sleep_instr), .wdt_expired(wdt_expired),
  .periph_sel(periph_sel), .periph_addr(periph_addr),
  .status(status), .bank(bank)
);

//--- bench/bdm_exec_model.sv
`timescale 1ns/100ps
module bdm_exec_model (
  // Clock.
  input wire logic ref_clk,
  // Requests to the core.
  output bdm_pkg::bdm_acc_t acc,
  output bdm_pkg::bdm_alu_req_t alu_req,
  output logic alu_valid,
  output logic [2:0] ev,
  // Answer from the core.
  input wire logic [7:0] rdata
);
  logic [7:0] got;
  initial begin
    acc = '0;
    alu_req = '0;
    alu_valid = 1'b0;
    ev = 3'h0;
    got = 8'h00;
  end
  // One instruction cycle; every request is held until the next edge.
  task automatic step(input bdm_pkg::bdm_acc_t a, input logic v,
      input bdm_pkg::bdm_alu_req_t q, input logic [2:0] e);
    @(posedge ref_clk);
    #1;
    acc = a;
    alu_valid = v;
    alu_req = q;
    ev = e;
    #2;
    got = rdata;
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
  logic ref_clk;
  logic resetn;
  logic por_reset;
  bdm_pkg::bdm_acc_t acc;
  bdm_pkg::bdm_alu_req_t alu_req;
  logic alu_valid;
  logic [2:0] ev;
  logic [7:0] rdata;
  logic [7:0] status;
  logic [4:0] bank;
  logic [7:0] alu_result;
  logic periph_we;
  logic [7:0] periph_wdata;
  int n_fail;
  int n_compared;
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  bdm_core i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .por_reset(por_reset),
    .acc(acc), .rdata(rdata), .alu_req(alu_req), .alu_valid(alu_valid),
    .alu_result(alu_result), .watchdog_clear_instr(ev[0]),
    .sleep_instr(ev[1]), .wdt_expired(ev[2]), .periph_sel(),
    .periph_we(periph_we), .periph_addr(), .periph_wdata(periph_wdata),
    .periph_rdata(8'h5a), .status(status), .bank(bank)
  );
  bdm_exec_model i_exec (
    .ref_clk(ref_clk), .acc(acc), .alu_req(alu_req),
    .alu_valid(alu_valid), .ev(ev), .rdata(rdata)
  );
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic mem(input logic w, input logic [6:0] o,
      input logic [7:0] d);
    i_exec.step({w, 2'b00, o, d}, 1'b0, 20'h0_0000, 3'h0);
  endtask
  task automatic rdc(input logic [6:0] o, input logic [7:0] exp);
    mem(1'b0, o, 8'h00);
    chk(i_exec.got, exp);
  endtask
  task automatic ird(input logic s, input logic [7:0] exp);
    i_exec.step({2'b01, s, 15'h0000}, 1'b0, 20'h0_0000, 3'h0);
    chk(i_exec.got, exp);
  endtask
  task automatic evt(input logic [2:0] e);
    i_exec.step('0, 1'b0, '0, e);
  endtask
  // The ALU result lands in the given offset; status is read back after.
  task automatic af(input bdm_pkg::bdm_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [6:0] o, input logic [7:0] exp);
    i_exec.step({3'b100, o, 8'h00}, 1'b1, {op, a, b}, 3'h0);
    rdc(7'h03, exp);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(7'h03, 8'h18);
    chk({3'b000, bank}, 8'h00);
    mem(1'b1, 7'h03, 8'hff);
    rdc(7'h03, 8'h1f);
    mem(1'b1, 7'h03, 8'h00);
    rdc(7'h03, 8'h18);
  endtask
  task automatic t_flags;
    af(bdm_pkg::BDM_OP_ADD, 8'h0f, 8'h01, 7'h20, 8'h1a);
    af(bdm_pkg::BDM_OP_ADD, 8'h80, 8'h80, 7'h20, 8'h1d);
    af(bdm_pkg::BDM_OP_SUB, 8'h05, 8'h05, 7'h20, 8'h1f);
    af(bdm_pkg::BDM_OP_SUB, 8'h03, 8'h05, 7'h20, 8'h18);
    af(bdm_pkg::BDM_OP_ROR, 8'h01, 8'h00, 7'h20, 8'h19);
    af(bdm_pkg::BDM_OP_ROL, 8'h7f, 8'h00, 7'h20, 8'h18);
    rdc(7'h20, 8'hff);
    af(bdm_pkg::BDM_OP_AND, 8'hf0, 8'h0f, 7'h20, 8'h1c);
    af(bdm_pkg::BDM_OP_OR, 8'h00, 8'h01, 7'h20, 8'h18);
    af(bdm_pkg::BDM_OP_CLR, 8'h5a, 8'h00, 7'h20, 8'h1c);
    af(bdm_pkg::BDM_OP_ADD, 8'h80, 8'h80, 7'h03, 8'h1d);
    i_exec.step('0, 1'b1, {bdm_pkg::BDM_OP_XOR, 8'h5a, 8'h0f}, 3'h0);
    chk(alu_result, 8'h55);
  endtask
  task automatic t_events;
    mem(1'b1, 7'h03, 8'h00);
    evt(3'b010);
    rdc(7'h03, 8'h10);
    evt(3'b100);
    rdc(7'h03, 8'h00);
    evt(3'b001);
    rdc(7'h03, 8'h18);
    evt(3'b100);
    evt(3'b010);
    rdc(7'h03, 8'h10);
  endtask
  task automatic t_banks;
    mem(1'b1, 7'h08, 8'h03);
    mem(1'b1, 7'h20, 8'ha5);
    chk({3'b000, bank}, 8'h03);
    mem(1'b1, 7'h70, 8'h3c);
    mem(1'b1, 7'h08, 8'h00);
    mem(1'b1, 7'h20, 8'h11);
    rdc(7'h70, 8'h3c);
    mem(1'b1, 7'h08, 8'h03);
    rdc(7'h20, 8'ha5);
    mem(1'b1, 7'h05, 8'h20);
    mem(1'b1, 7'h04, 8'hf0);
    ird(1'b0, 8'ha5);
    mem(1'b1, 7'h07, 8'h01);
    mem(1'b1, 7'h06, 8'ha0);
    ird(1'b1, 8'ha5);
    mem(1'b1, 7'h07, 8'h80);
    ird(1'b1, 8'h00);
    rdc(7'h0c, 8'h5a);
    mem(1'b1, 7'h0c, 8'h66);
    chk({7'h00, periph_we}, 8'h01);
    chk(periph_wdata, 8'h66);
    mem(1'b1, 7'h08, 8'h00);
    rdc(7'h04, 8'hf0);
  endtask
  // A warm reset must leave the arithmetic flags alone.
  task automatic t_warm;
    mem(1'b1, 7'h03, 8'h07);
    // A plain read takes the write, so no write is held through reset.
    mem(1'b0, 7'h20, 8'h00);
    @(posedge ref_clk);
    #1;
    resetn = 1'b0;
    por_reset = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    rdc(7'h03, 8'h1f);
  endtask
  initial begin
    resetn = 1'b0;
    por_reset = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_flags();
    t_events();
    t_banks();
    t_warm();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
endmodule
